// [shared/isp_pkg.sv]
/*
 * isp_pkg: object indices, reset values, mode codes and capability bits of
 * the input synchronisation parameter bank.
 * assumes: the mailbox object directory delivers index/subindex accesses.
 */
package isp_pkg;
    // object indices (upper 16 bits) and subindices
    localparam logic [15:0] IDX_SYNC    = 16'h1C33;
    localparam logic [15:0] IDX_PROFILE = 16'hF000;
    localparam logic [15:0] IDX_CODE    = 16'hF008;
    localparam logic [7:0]  SUB_COUNT   = 8'h00;
    localparam logic [7:0]  SUB_MODE    = 8'h01;
    localparam logic [7:0]  SUB_PERIOD  = 8'h02;
    localparam logic [7:0]  SUB_SHIFT   = 8'h03;
    localparam logic [7:0]  SUB_CAPS    = 8'h04;
    localparam logic [7:0]  SUB_MINPER  = 8'h05;
    localparam logic [7:0]  SUB_READY   = 8'h06;
    localparam logic [7:0]  SUB_MINDLY  = 8'h07;
    localparam logic [7:0]  SUB_CMD     = 8'h08;
    localparam logic [7:0]  SUB_MAXDLY  = 8'h09;
    localparam logic [7:0]  SUB_MISSED  = 8'h0B;
    localparam logic [7:0]  SUB_OVERRUN = 8'h0C;
    localparam logic [7:0]  SUB_SHORT   = 8'h0D;
    localparam logic [7:0]  SUB_FAULT   = 8'h20;
    localparam logic [7:0]  SUB_SPACING = 8'h01;
    localparam logic [7:0]  SUB_CHCOUNT = 8'h02;
    // reset values and constants
    localparam logic [7:0]  RST_ENTRY_COUNT   = 8'h20;
    localparam logic [15:0] RST_MODE          = 16'h0001;
    localparam logic [31:0] RST_PERIOD        = 32'h000F4240;
    localparam logic [31:0] RST_MIN_PERIOD    = 32'h000186A0;
    localparam logic [15:0] RST_CAPS          = 16'h0002;
    localparam logic [7:0]  RST_PROFILE_COUNT = 8'h02;
    localparam logic [15:0] RST_SPACING       = 16'h0010;
    localparam logic [15:0] RST_CHANNELS      = 16'h0010;
    localparam logic [31:0] LOCK_CODE         = 32'h12345678;
    // capability bit positions
    localparam int CAP_FREE_BIT    = 0;
    localparam int CAP_BUF_BIT     = 1;
    localparam int CAP_DC_LSB      = 2;
    localparam int CAP_SHIFT_LSB   = 4;
    localparam int CAP_DYNAMIC_BIT = 14;
    localparam logic [1:0] CAP_DC_YES      = 2'h1;
    localparam logic [1:0] CAP_SHIFT_LOCAL = 2'h1;
    localparam logic [1:0] CAP_SHIFT_SYNC1 = 2'h2;
    localparam logic [7:0] REV_DYN_LO = 8'h11;
    localparam logic [7:0] REV_DYN_HI = 8'h19;
    // mode codes
    localparam logic [15:0] MODE_FREE  = 16'h0000;
    localparam logic [15:0] MODE_INBUF = 16'h0001;
    localparam logic [15:0] MODE_SYNC0 = 16'h0002;
    localparam logic [15:0] MODE_SYNC1 = 16'h0003;
    localparam logic [15:0] MODE_OUTBUF= 16'h0022;
    typedef enum logic [2:0] {ISP_FREE, ISP_INBUF, ISP_SYNC0, ISP_SYNC1, ISP_OUTBUF, ISP_BAD} isp_mode_e;
endpackage

// [core/isp_bank.sv]
/*
 * isp_bank: input synchronisation parameter objects of the output terminal,
 * timing measurement, diagnostic counters and persistence lock.
 * assumes: one-cycle access strobes from the mailbox object directory; timing
 * events arrive as synchronous one-cycle pulses with times already in ns.
 */
// Contract
// - mode codes 0,1,2,3,34 select synchronisation
// - report sync0-to-sample delay, dc only
// - capability bits: free, buffer, dc, shift; free bit 0 is never set
// - bit 14 dynamic times, revisions 17-25
// - report sample-to-ready time, dc only
// - report max sync1-to-sample delay, dc only
// - code 0x12345678 suspends persistent storage
// - other code or restart leaves suspension
// - profile spacing 16, channel count 16
// - command 1 starts, 0 stops max measurement
// - count missed, overrun, short-shift while operational; missed and short-shift only in dc mode
// - sync fault flag for last cycle, dc
`timescale 1ns/1ps
module isp_bank
    import isp_pkg::*;
#(
    parameter logic [7:0] HW_REVISION = 8'h11,
    parameter bit         DC_CAPABLE  = 1'b0,
    parameter bit         SHIFT_SYNC1 = 1'b1
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // object access
    input  wire logic        obj_rd,
    input  wire logic        obj_wr,
    input  wire logic [15:0] obj_index,
    input  wire logic [7:0]  obj_sub,
    input  wire logic [31:0] obj_wdata,
    output logic [31:0]      obj_rdata,
    output logic             obj_ack,
    output logic             obj_err,
    // timing events
    input  wire logic        operational,
    input  wire logic        cycle_done,
    input  wire logic [31:0] meas_shift_ns,
    input  wire logic [31:0] meas_ready_ns,
    input  wire logic [31:0] meas_max_dly_ns,
    input  wire logic        evt_missed,
    input  wire logic        evt_overrun,
    input  wire logic        evt_short,
    input  wire logic        cycle_sync_bad,
    // status
    output isp_pkg::isp_mode_e active_mode,
    output logic             suspend_param_persistence
);
    import isp_pkg::*;

    typedef struct packed {
        logic [15:0] mode;
        logic [31:0] period;
        logic [15:0] cmd;
        logic [31:0] shift;
        logic [31:0] ready;
        logic [31:0] maxdly;
        logic [15:0] missed;
        logic [15:0] overrun;
        logic [15:0] short_cnt;
        logic        fault;
        logic [31:0] code;
        logic        suspend;
        logic [31:0] rdata;
        logic        ack;
        logic        err;
    } isp_state_s;

    isp_state_s st;
    isp_state_s next_st;

    function automatic isp_mode_e decode_mode(input logic [15:0] m);
        unique case (m)
            MODE_FREE:   decode_mode = ISP_FREE;
            MODE_INBUF:  decode_mode = ISP_INBUF;
            MODE_SYNC0:  decode_mode = ISP_SYNC0;
            MODE_SYNC1:  decode_mode = ISP_SYNC1;
            MODE_OUTBUF: decode_mode = ISP_OUTBUF;
            default:     decode_mode = ISP_BAD;
        endcase
    endfunction

    function automatic logic [15:0] caps_word();
        logic [15:0] c;
        c = '0;
        c[CAP_BUF_BIT] = 1'b1;
        if (DC_CAPABLE) begin
            c[CAP_DC_LSB +: 2]    = CAP_DC_YES;
            c[CAP_SHIFT_LSB +: 2] = SHIFT_SYNC1 ? CAP_SHIFT_SYNC1 : CAP_SHIFT_LOCAL;
        end
        if (HW_REVISION >= REV_DYN_LO && HW_REVISION <= REV_DYN_HI) begin
            c[CAP_DYNAMIC_BIT] = 1'b1;
        end
        return c;
    endfunction

    isp_mode_e mode_now;
    logic      dc_mode;
    logic      measuring;
    logic      wr_ok;
    logic      hit_sync;
    logic      hit_prof;
    logic      hit_code;

    assign mode_now  = decode_mode(st.mode);
    assign dc_mode   = (mode_now == ISP_SYNC0) || (mode_now == ISP_SYNC1);
    assign measuring = (st.cmd == 16'h0001);
    assign hit_sync  = (obj_index == IDX_SYNC);
    assign hit_prof  = (obj_index == IDX_PROFILE);
    assign hit_code  = (obj_index == IDX_CODE) && (obj_sub == SUB_COUNT);

    always_comb begin
        next_st     = st;
        next_st.ack = 1'b0;
        next_st.err = 1'b0;
        wr_ok       = 1'b0;

        // measurement: running maxima in dc mode only
        if (cycle_done && measuring && dc_mode) begin
            if (meas_shift_ns > st.shift) begin
                next_st.shift = meas_shift_ns;
            end
            if (meas_ready_ns > st.ready) begin
                next_st.ready = meas_ready_ns;
            end
            if (meas_max_dly_ns > st.maxdly) begin
                next_st.maxdly = meas_max_dly_ns;
            end
        end
        if (cycle_done) begin
            next_st.fault = dc_mode && cycle_sync_bad;
        end

        // counters saturate rather than wrap, so a count never looks small
        if (operational && evt_missed && dc_mode && st.missed != 16'hFFFF) begin
            next_st.missed = st.missed + 16'h0001;
        end
        if (operational && evt_overrun && st.overrun != 16'hFFFF) begin
            next_st.overrun = st.overrun + 16'h0001;
        end
        if (operational && evt_short && dc_mode && st.short_cnt != 16'hFFFF) begin
            next_st.short_cnt = st.short_cnt + 16'h0001;
        end

        if (obj_wr) begin
            next_st.ack = 1'b1;
            if (hit_sync && obj_sub == SUB_MODE) begin
                wr_ok = 1'b1;
                next_st.mode = obj_wdata[15:0];
            end else if (hit_sync && obj_sub == SUB_PERIOD) begin
                wr_ok = 1'b1;
                next_st.period = obj_wdata;
            end else if (hit_sync && obj_sub == SUB_CMD) begin
                wr_ok = 1'b1;
                next_st.cmd = obj_wdata[15:0];
                if (obj_wdata[15:0] == 16'h0001) begin
                    next_st.shift  = '0;
                    next_st.ready  = '0;
                    next_st.maxdly = '0;
                end
            end else if (hit_code) begin
                wr_ok = 1'b1;
                next_st.code    = obj_wdata;
                next_st.suspend = (obj_wdata == LOCK_CODE);
            end
            next_st.err = !wr_ok;
        end else if (obj_rd) begin
            next_st.ack   = 1'b1;
            next_st.rdata = '0;
            if (hit_sync) begin
                unique case (obj_sub)
                    SUB_COUNT:   next_st.rdata = {24'h0, RST_ENTRY_COUNT};
                    SUB_MODE:    next_st.rdata = {16'h0, st.mode};
                    SUB_PERIOD:  next_st.rdata = st.period;
                    SUB_SHIFT:   next_st.rdata = st.shift;
                    SUB_CAPS:    next_st.rdata = {16'h0, caps_word()};
                    SUB_MINPER:  next_st.rdata = RST_MIN_PERIOD;
                    SUB_READY:   next_st.rdata = st.ready;
                    SUB_MINDLY:  next_st.rdata = 32'h0;
                    SUB_CMD:     next_st.rdata = {16'h0, st.cmd};
                    SUB_MAXDLY:  next_st.rdata = st.maxdly;
                    SUB_MISSED:  next_st.rdata = {16'h0, st.missed};
                    SUB_OVERRUN: next_st.rdata = {16'h0, st.overrun};
                    SUB_SHORT:   next_st.rdata = {16'h0, st.short_cnt};
                    SUB_FAULT:   next_st.rdata = {31'h0, st.fault};
                    default:     next_st.err   = 1'b1;
                endcase
            end else if (hit_prof) begin
                unique case (obj_sub)
                    SUB_COUNT:   next_st.rdata = {24'h0, RST_PROFILE_COUNT};
                    SUB_SPACING: next_st.rdata = {16'h0, RST_SPACING};
                    SUB_CHCOUNT: next_st.rdata = {16'h0, RST_CHANNELS};
                    default:     next_st.err   = 1'b1;
                endcase
            end else if (hit_code) begin
                next_st.rdata = st.code;
            end else begin
                next_st.err = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st         <= '0;
            st.mode    <= RST_MODE;
            st.period  <= RST_PERIOD;
            st.suspend <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign obj_rdata                 = st.rdata;
    assign obj_ack                   = st.ack;
    assign obj_err                   = st.err;
    assign active_mode               = mode_now;
    assign suspend_param_persistence = st.suspend;

    a_lock_code: assert property (@(posedge clk_sys) disable iff (reset)
        obj_wr && hit_code && obj_wdata == LOCK_CODE |=> suspend_param_persistence)
        else $error("lock code did not suspend persistence");
    a_lock_leave: assert property (@(posedge clk_sys) disable iff (reset)
        obj_wr && hit_code && obj_wdata != LOCK_CODE |=> !suspend_param_persistence)
        else $error("suspension kept after code change");
    a_ro_reject: assert property (@(posedge clk_sys) disable iff (reset)
        obj_wr && hit_sync && obj_sub == SUB_SHIFT && !cycle_done |=> obj_err && $stable(st.shift))
        else $error("read-only write not rejected");
    a_meas_reset: assert property (@(posedge clk_sys) disable iff (reset)
        obj_wr && hit_sync && obj_sub == SUB_CMD && obj_wdata[15:0] == 16'h0001
        |=> st.shift == 32'h0 && st.maxdly == 32'h0)
        else $error("measurement start did not clear maxima");
    a_meas_stop: assert property (@(posedge clk_sys) disable iff (reset)
        !measuring && !(obj_wr && hit_sync) |=> $stable(st.shift))
        else $error("shift time moved while stopped");
    a_ready_max: assert property (@(posedge clk_sys) disable iff (reset)
        !(obj_wr && hit_sync) |=> st.ready >= $past(st.ready))
        else $error("ready latency decreased");
    a_max_dly: assert property (@(posedge clk_sys) disable iff (reset)
        cycle_done && measuring && dc_mode && !obj_wr |=> st.maxdly >= $past(meas_max_dly_ns))
        else $error("max delay not captured");
    a_fault_dc: assert property (@(posedge clk_sys) disable iff (reset)
        cycle_done && !dc_mode |=> !st.fault)
        else $error("sync fault outside dc mode");
    a_overrun_cnt: assert property (@(posedge clk_sys) disable iff (reset)
        operational && evt_overrun && st.overrun < 16'hFFFF && !obj_wr
        |=> st.overrun == $past(st.overrun) + 16'h0001)
        else $error("overrun not counted");
    a_profile: assert property (@(posedge clk_sys) disable iff (reset)
        obj_rd && !obj_wr && hit_prof && obj_sub == SUB_SPACING |=> obj_rdata == 32'h00000010)
        else $error("channel spacing wrong");
    a_mode_map: assert property (@(posedge clk_sys) disable iff (reset)
        st.mode == MODE_OUTBUF |-> active_mode == ISP_OUTBUF)
        else $error("mode 34 not decoded");
    a_caps_buf: assert property (@(posedge clk_sys) disable iff (reset)
        obj_rd && !obj_wr && hit_sync && obj_sub == SUB_CAPS |=> obj_rdata[1] && !obj_rdata[0])
        else $error("capability word wrong");
    a_caps_dyn: assert property (@(posedge clk_sys) disable iff (reset)
        obj_rd && !obj_wr && hit_sync && obj_sub == SUB_CAPS
        |=> obj_rdata[14] == (HW_REVISION >= REV_DYN_LO && HW_REVISION <= REV_DYN_HI))
        else $error("dynamic-times bit wrong");
    a_missed_cnt: assert property (@(posedge clk_sys) disable iff (reset)
        operational && evt_missed && dc_mode && st.missed < 16'hFFFF
        |=> st.missed == $past(st.missed) + 16'h0001)
        else $error("missed event not counted");
    a_short_cnt: assert property (@(posedge clk_sys) disable iff (reset)
        operational && evt_short && dc_mode && st.short_cnt < 16'hFFFF
        |=> st.short_cnt == $past(st.short_cnt) + 16'h0001)
        else $error("short shift not counted");
    a_count_gate: assert property (@(posedge clk_sys) disable iff (reset)
        !operational
        |=> $stable(st.missed) && $stable(st.overrun) && $stable(st.short_cnt))
        else $error("counter moved while not operational");
    a_fault_set: assert property (@(posedge clk_sys) disable iff (reset)
        cycle_done && dc_mode && cycle_sync_bad |=> st.fault)
        else $error("sync fault not flagged");
    a_shift_cap: assert property (@(posedge clk_sys) disable iff (reset)
        cycle_done && measuring && dc_mode && !obj_wr |=> st.shift >= $past(meas_shift_ns))
        else $error("shift time not captured");
    a_ready_cap: assert property (@(posedge clk_sys) disable iff (reset)
        cycle_done && measuring && dc_mode && !obj_wr |=> st.ready >= $past(meas_ready_ns))
        else $error("ready latency not captured");
    a_cmd_stop: assert property (@(posedge clk_sys) disable iff (reset)
        obj_wr && hit_sync && obj_sub == SUB_CMD && obj_wdata[15:0] == 16'h0000 |=> !measuring)
        else $error("measurement not stopped");
    a_chan_count: assert property (@(posedge clk_sys) disable iff (reset)
        obj_rd && !obj_wr && hit_prof && obj_sub == SUB_CHCOUNT |=> obj_rdata == 32'h00000010)
        else $error("channel count wrong");
    a_ro_prof: assert property (@(posedge clk_sys) disable iff (reset)
        obj_wr && hit_prof |=> obj_err)
        else $error("profile write not rejected");
    a_caps_dc: assert property (@(posedge clk_sys) disable iff (reset)
        obj_rd && !obj_wr && hit_sync && obj_sub == SUB_CAPS |=> obj_rdata[3:2] == (DC_CAPABLE ? CAP_DC_YES : 2'h0))
        else $error("dc capability bits wrong");
    a_caps_shift: assert property (@(posedge clk_sys) disable iff (reset)
        obj_rd && !obj_wr && hit_sync && obj_sub == SUB_CAPS
        |=> obj_rdata[5:4] == (DC_CAPABLE ? (SHIFT_SYNC1 ? CAP_SHIFT_SYNC1 : CAP_SHIFT_LOCAL) : 2'h0))
        else $error("input shift capability bits wrong");
    a_lock_reset: assert property (@(posedge clk_sys)
        reset |=> !suspend_param_persistence)
        else $error("restart kept suspension");
endmodule

// [sim/isp_evt_src.sv]
/*
 * isp_evt_src: model of the sync unit that feeds cycle ends, measured
 * times and diagnostic events to the parameter bank.
 * assumes: called from the bench by task, one clock, one call at a time.
 */
`timescale 1ns/1ps
module isp_evt_src (
    // clock
    input  wire logic   clk_sys,
    // events towards the bank
    output logic        cycle_done,
    output logic [31:0] meas_shift_ns,
    output logic [31:0] meas_ready_ns,
    output logic [31:0] meas_max_dly_ns,
    output logic        evt_missed,
    output logic        evt_overrun,
    output logic        evt_short,
    output logic        cycle_sync_bad
);
    initial begin
        {cycle_done, evt_missed, evt_overrun, evt_short, cycle_sync_bad} = 5'h00;
        {meas_shift_ns, meas_ready_ns, meas_max_dly_ns} = 96'h0;
    end

    // times valid only with the pulse; inverted after so stale values show
    task automatic cycle(input logic [31:0] sh, input logic [31:0] rd, input logic [31:0] mx, input logic bad);
        @(posedge clk_sys);
        cycle_done <= 1'b1;
        {meas_shift_ns, meas_ready_ns, meas_max_dly_ns, cycle_sync_bad} <= {sh, rd, mx, bad};
        @(posedge clk_sys);
        cycle_done <= 1'b0;
        {meas_shift_ns, meas_ready_ns, meas_max_dly_ns, cycle_sync_bad} <= ~{sh, rd, mx, bad};
    endtask

    // one-cycle diagnostic events
    task automatic pulse(input logic m, input logic o, input logic s);
        @(posedge clk_sys);
        {evt_missed, evt_overrun, evt_short} <= {m, o, s};
        @(posedge clk_sys);
        {evt_missed, evt_overrun, evt_short} <= 3'h0;
    endtask
endmodule

// [sim/testbench.sv]
/*
 * testbench: object reads and writes against the parameter bank, with
 * expected values from the package constants.
 * assumes: one-cycle strobes, ack exactly one cycle later.
 */
`timescale 1ns/1ps
module testbench;
    import isp_pkg::*;
    logic        clk_sys, reset, obj_rd, obj_wr, obj_ack, obj_err, operational, re;
    logic [15:0] obj_index;
    logic [7:0]  obj_sub;
    logic [31:0] obj_wdata, obj_rdata, meas_shift_ns, meas_ready_ns, meas_max_dly_ns, rv;
    logic        cycle_done, evt_missed, evt_overrun, evt_short, cycle_sync_bad, suspend_param_persistence;
    isp_mode_e   active_mode;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cyc = 0;
    // dc capable, shift with second pulse, revision inside the dynamic range
    localparam logic [15:0] CAPS = RST_CAPS | {12'h000, CAP_DC_YES, 2'h0} | {10'h000, CAP_SHIFT_SYNC1, 4'h0} | 16'h4000;
    // read-only entries first, command last
    localparam logic [7:0] ZS [9] = '{SUB_SHIFT, SUB_READY, SUB_MINDLY, SUB_MAXDLY, SUB_MISSED, SUB_OVERRUN,
                                      SUB_SHORT, SUB_FAULT, SUB_CMD};
    localparam logic [15:0] MODES [6] = '{MODE_FREE, MODE_INBUF, MODE_SYNC0, MODE_SYNC1, MODE_OUTBUF, 16'h0004};

    isp_bank #(.HW_REVISION(8'h11), .DC_CAPABLE(1'b1), .SHIFT_SYNC1(1'b1)) isp_bank_i (
        .clk_sys(clk_sys), .reset(reset), .obj_rd(obj_rd), .obj_wr(obj_wr), .obj_index(obj_index),
        .obj_sub(obj_sub), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
        .operational(operational), .cycle_done(cycle_done), .meas_shift_ns(meas_shift_ns),
        .meas_ready_ns(meas_ready_ns), .meas_max_dly_ns(meas_max_dly_ns), .evt_missed(evt_missed),
        .evt_overrun(evt_overrun), .evt_short(evt_short), .cycle_sync_bad(cycle_sync_bad),
        .active_mode(active_mode), .suspend_param_persistence(suspend_param_persistence));
    isp_evt_src isp_evt_src_i (
        .clk_sys(clk_sys), .cycle_done(cycle_done), .meas_shift_ns(meas_shift_ns),
        .meas_ready_ns(meas_ready_ns), .meas_max_dly_ns(meas_max_dly_ns), .evt_missed(evt_missed),
        .evt_overrun(evt_overrun), .evt_short(evt_short), .cycle_sync_bad(cycle_sync_bad));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one strobe, answer sampled once the ack edge has landed
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
        @(posedge clk_sys);
        {obj_wr, obj_rd, obj_index, obj_sub, obj_wdata} <= {w, ~w, i, s, d};
        @(posedge clk_sys);
        {obj_wr, obj_rd} <= 2'h0;
        #1;
        chk("ack", {31'h0, obj_ack}, 32'h1);
        rv = obj_rdata;
        re = obj_err;
    endtask

    task automatic rchk(input string nm, input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
        acc(1'b0, i, s, 32'h0);
        chk(nm, rv, e);
        chk("read err", {31'h0, re}, 32'h0);
    endtask

    task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic e);
        acc(1'b1, i, s, d);
        chk("write err", {31'h0, re}, {31'h0, e});
    endtask

    task automatic do_reset(input int n);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (n) @(posedge clk_sys);
        reset <= 1'b0;
    endtask

    task automatic chk_defaults();
        rchk("entry count", IDX_SYNC, SUB_COUNT, {24'h0, RST_ENTRY_COUNT});
        rchk("mode", IDX_SYNC, SUB_MODE, {16'h0, RST_MODE});
        rchk("period", IDX_SYNC, SUB_PERIOD, RST_PERIOD);
        rchk("caps", IDX_SYNC, SUB_CAPS, {16'h0, CAPS});
        rchk("min period", IDX_SYNC, SUB_MINPER, RST_MIN_PERIOD);
        foreach (ZS[k]) rchk("zero entry", IDX_SYNC, ZS[k], 32'h0);
        rchk("profile count", IDX_PROFILE, SUB_COUNT, {24'h0, RST_PROFILE_COUNT});
        rchk("spacing", IDX_PROFILE, SUB_SPACING, {16'h0, RST_SPACING});
        rchk("channels", IDX_PROFILE, SUB_CHCOUNT, {16'h0, RST_CHANNELS});
        rchk("code", IDX_CODE, SUB_COUNT, 32'h0);
        chk("suspend", {31'h0, suspend_param_persistence}, 32'h0);
        chk("active mode", {29'h0, active_mode}, {29'h0, ISP_INBUF});
    endtask

    initial begin
        {reset, obj_rd, obj_wr, operational, obj_index, obj_sub, obj_wdata} = {4'h8, 56'h0};
        do_reset(6);
        chk_defaults();
        // read-only and unmapped places refuse and keep their value
        for (int k = 0; k < 8; k++) wr(IDX_SYNC, ZS[k], 32'hA5A5A5A5, 1'b1);
        wr(IDX_SYNC, SUB_CAPS, 32'h0000FFFF, 1'b1);
        wr(IDX_SYNC, SUB_COUNT, 32'h00000011, 1'b1);
        wr(IDX_PROFILE, SUB_SPACING, 32'h00000020, 1'b1);
        wr(IDX_PROFILE, SUB_CHCOUNT, 32'h00000001, 1'b1);
        wr(16'h1C34, SUB_MODE, 32'h0, 1'b1);
        acc(1'b0, IDX_SYNC, 8'h0A, 32'h0);
        chk("unmapped read err", {31'h0, re}, 32'h1);
        chk_defaults();
        // every mode code, plus one undefined
        foreach (MODES[k]) begin
            wr(IDX_SYNC, SUB_MODE, {16'h0, MODES[k]}, 1'b0);
            rchk("mode back", IDX_SYNC, SUB_MODE, {16'h0, MODES[k]});
            chk("active mode", {29'h0, active_mode}, 32'(k));
        end
        wr(IDX_SYNC, SUB_PERIOD, 32'h0007A120, 1'b0);
        rchk("period back", IDX_SYNC, SUB_PERIOD, 32'h0007A120);
        // measurement of maxima in dc mode
        wr(IDX_SYNC, SUB_MODE, {16'h0, MODE_SYNC0}, 1'b0);
        operational <= 1'b1;
        wr(IDX_SYNC, SUB_CMD, 32'h1, 1'b0);
        isp_evt_src_i.cycle(32'd100, 32'd200, 32'd300, 1'b1);
        rchk("fault set", IDX_SYNC, SUB_FAULT, 32'h1);
        isp_evt_src_i.cycle(32'd50, 32'd400, 32'd10, 1'b0);
        rchk("fault clear", IDX_SYNC, SUB_FAULT, 32'h0);
        rchk("shift max", IDX_SYNC, SUB_SHIFT, 32'd100);
        rchk("ready max", IDX_SYNC, SUB_READY, 32'd400);
        rchk("delay max", IDX_SYNC, SUB_MAXDLY, 32'd300);
        wr(IDX_SYNC, SUB_CMD, 32'h0, 1'b0);
        isp_evt_src_i.cycle(32'd900, 32'd900, 32'd900, 1'b0);
        rchk("stopped", IDX_SYNC, SUB_SHIFT, 32'd100);
        wr(IDX_SYNC, SUB_CMD, 32'h1, 1'b0);
        rchk("restart clears", IDX_SYNC, SUB_READY, 32'h0);
        wr(IDX_SYNC, SUB_MODE, {16'h0, MODE_FREE}, 1'b0);
        isp_evt_src_i.cycle(32'd700, 32'd700, 32'd700, 1'b0);
        rchk("free run no shift", IDX_SYNC, SUB_SHIFT, 32'h0);
        // diagnostic counters
        wr(IDX_SYNC, SUB_MODE, {16'h0, MODE_SYNC1}, 1'b0);
        repeat (2) isp_evt_src_i.pulse(1'b1, 1'b1, 1'b1);
        isp_evt_src_i.pulse(1'b0, 1'b1, 1'b0);
        operational <= 1'b0;
        isp_evt_src_i.pulse(1'b1, 1'b1, 1'b1);
        operational <= 1'b1;
        wr(IDX_SYNC, SUB_MODE, {16'h0, MODE_FREE}, 1'b0);
        isp_evt_src_i.pulse(1'b1, 1'b1, 1'b1);
        rchk("missed", IDX_SYNC, SUB_MISSED, 32'd2);
        rchk("overrun", IDX_SYNC, SUB_OVERRUN, 32'd4);
        rchk("short", IDX_SYNC, SUB_SHORT, 32'd2);
        // persistence lock: set, change, set, restart
        wr(IDX_CODE, SUB_COUNT, LOCK_CODE, 1'b0);
        chk("suspend on", {31'h0, suspend_param_persistence}, 32'h1);
        rchk("code back", IDX_CODE, SUB_COUNT, LOCK_CODE);
        wr(IDX_CODE, SUB_COUNT, 32'h12345679, 1'b0);
        chk("suspend off", {31'h0, suspend_param_persistence}, 32'h0);
        wr(IDX_CODE, SUB_COUNT, LOCK_CODE, 1'b0);
        chk("suspend again", {31'h0, suspend_param_persistence}, 32'h1);
        operational <= 1'b0;
        do_reset(2);
        #1;
        chk_defaults();
        end_of_test();
    end
endmodule
